// ===== rrre_pkg.sv
// shared constants and types of the return, reset and rotate execution block
// Notes on behaviour
// - the software reset opcode requests a device reset, touching no flag.
// - the software reset opcode clears soft_reset_indicator.
// - return_and_enable_irq pops the stack into the PC, carry untouched.
// - return_and_enable_irq sets global_irq_enable, one word, two cycles.
// - return_with_literal loads W with its literal and pops PC, two cycles.
// - return, coded 0000 0000 0001 001s, pops in two cycles, no flags.
// - rotate_left_carry puts bit 7 in carry, old carry in bit 0, only carry.
// - for rotate_left_carry destination 0 writes W and 1 the file register.
// - rotate_left_carry decodes 0011 01da ffff ffff, 7-bit address, 1 cycle.
`default_nettype none
package rrre_pkg;
  // ****************************************************************
  // widths and sizes
  // ****************************************************************
  localparam int unsigned INSTR_W = 16;
  localparam int unsigned PC_W = 15;
  localparam int unsigned STACK_DEPTH = 16;
  localparam int unsigned ADR_W = 8;
  localparam int unsigned FADR_W = 7;

  // ****************************************************************
  // opcodes and fields
  // ****************************************************************
  localparam logic [15:0] OP_RESET = 16'h0001;
  localparam logic [15:0] OP_RET_IRQ = 16'h0010;
  localparam logic [14:0] OP_RETURN_HI = 15'h0009;
  localparam logic [7:0] OP_RET_LIT_HI = 8'h0C;
  localparam logic [5:0] OP_ROT_HI = 6'h0D;
  localparam int unsigned ROT_DEST_BIT = 9;

  // ****************************************************************
  // register offsets, bit positions and reset values
  // ****************************************************************
  localparam logic [7:0] REG_IRQ_CTRL = 8'h00;
  localparam logic [7:0] REG_PWR_STAT = 8'h04;
  localparam logic [7:0] REG_CORE_STAT = 8'h08;
  localparam logic [7:0] REG_WORK = 8'h0C;
  localparam logic [7:0] REG_STACK_PTR = 8'h10;
  localparam logic [7:0] REG_PROG_CNT = 8'h14;
  localparam int unsigned IRQ_EN_BIT = 7;
  localparam int unsigned SRI_BIT = 2;
  localparam int unsigned CARRY_BIT = 0;
  localparam logic RST_IRQ_EN = 1'b0;
  localparam logic RST_SRI = 1'b1;
  localparam logic RST_CARRY = 1'b0;
  localparam logic [7:0] RST_WORK = 8'h00;

  // ****************************************************************
  // execution states
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SECOND = 2'b10
  } rrre_state_type;
endpackage : rrre_pkg
`default_nettype wire

// ===== rrre_stack_mem.sv
// return address stack storage with registered read data
`timescale 1ns/1ns
`default_nettype none
module rrre_stack_mem #(
  parameter int unsigned DEPTH = 16,
  parameter int unsigned WIDTH = 15,
  parameter int unsigned AW = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] rdata_q;

  // ****************************************************************
  // storage
  // ****************************************************************
  // array write, no reset on the cells
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  // read port registered every cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem_q[raddr_i];
    end
  end

  assign rdata_o = rdata_q;
endmodule : rrre_stack_mem
`default_nettype wire

// ===== rrre_exec.sv
// execution unit for software reset, the three returns and rotate left
`timescale 1ns/1ns
`default_nettype none
module rrre_exec #(
  parameter int unsigned STACK_DEPTH = rrre_pkg::STACK_DEPTH
) (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [rrre_pkg::ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic INSTR_VALID_I,
  input wire logic [rrre_pkg::INSTR_W-1:0] INSTR_I,
  output logic INSTR_READY_O,
  output logic [rrre_pkg::FADR_W-1:0] FILE_RADDR_O,
  input wire logic [7:0] FILE_RDATA_I,
  output logic [rrre_pkg::FADR_W-1:0] FILE_WADDR_O,
  output logic [7:0] FILE_WDATA_O,
  output logic FILE_WE_O,
  input wire logic PUSH_I,
  input wire logic [rrre_pkg::PC_W-1:0] PUSH_PC_I,
  output logic PUSH_READY_O,
  output logic [rrre_pkg::PC_W-1:0] PC_O,
  output logic PC_LOAD_O,
  output logic [7:0] W_O,
  output logic CARRY_O,
  output logic GLOBAL_IRQ_ENABLE_O,
  output logic DEV_RESET_REQ_O
);
  localparam int unsigned SP_W = $clog2(STACK_DEPTH);

  // ****************************************************************
  // declarations
  // ****************************************************************
  rrre_pkg::rrre_state_type state_q;
  rrre_pkg::rrre_state_type state_d;
  logic idle;
  logic accept;
  logic is_reset;
  logic is_ret_irq;
  logic is_return;
  logic is_ret_lit;
  logic is_rot;
  logic do_reset;
  logic do_ret;
  logic do_rot;
  logic pop;
  logic push_fire;
  logic rot_to_file;
  logic [7:0] rot_result;
  logic [rrre_pkg::PC_W-1:0] stack_top_value;
  logic [SP_W-1:0] sp_q;
  logic [SP_W-1:0] sp_d;
  logic [SP_W-1:0] sp_top;
  logic ret_irq_q;
  logic ret_lit_q;
  logic [7:0] lit_q;
  logic global_irq_enable_q;
  logic global_irq_enable_d;
  logic soft_reset_indicator_q;
  logic soft_reset_indicator_d;
  logic carry_q;
  logic carry_d;
  logic [7:0] w_q;
  logic [7:0] w_d;
  logic [rrre_pkg::PC_W-1:0] pc_q;
  logic pc_load_q;
  logic reset_req_q;
  logic file_we_q;
  logic [7:0] file_wdata_q;
  logic [rrre_pkg::FADR_W-1:0] file_waddr_q;
  logic bus_req;
  logic bus_wr;
  logic wr_irq;
  logic wr_pwr;
  logic wr_stat;
  logic wr_work;
  logic ack_q;
  logic [31:0] rd_data;
  logic [31:0] dat_q;

  // ****************************************************************
  // instruction decode
  // ****************************************************************
  // one instruction at a time, the second cycle of a return stalls
  assign idle = state_q == rrre_pkg::ST_IDLE;
  assign INSTR_READY_O = idle;
  assign accept = INSTR_VALID_I && idle;
  assign is_reset = INSTR_I == rrre_pkg::OP_RESET;
  assign is_ret_irq = INSTR_I == rrre_pkg::OP_RET_IRQ;
  assign is_return = INSTR_I[15:1] == rrre_pkg::OP_RETURN_HI;
  assign is_ret_lit = INSTR_I[15:8] == rrre_pkg::OP_RET_LIT_HI;
  assign is_rot = INSTR_I[15:10] == rrre_pkg::OP_ROT_HI;
  assign do_reset = accept && is_reset;
  assign do_ret = accept && (is_ret_irq || is_return || is_ret_lit);
  assign do_rot = accept && is_rot;
  assign pop = state_q == rrre_pkg::ST_SECOND;

  // rotate datapath, old carry enters bit 0
  assign FILE_RADDR_O = INSTR_I[rrre_pkg::FADR_W-1:0];
  assign rot_to_file = INSTR_I[rrre_pkg::ROT_DEST_BIT];
  assign rot_result = {FILE_RDATA_I[6:0], carry_q};

  // ****************************************************************
  // return stack
  // ****************************************************************
  // pushes only while idle so they never meet a pop
  assign PUSH_READY_O = idle && !INSTR_VALID_I;
  assign push_fire = PUSH_I && PUSH_READY_O;
  assign sp_top = sp_q - SP_W'(1);

  rrre_stack_mem #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(rrre_pkg::PC_W),
    .AW(SP_W)
  ) u_stack (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .we_i(push_fire),
    .waddr_i(sp_q),
    .wdata_i(PUSH_PC_I),
    .raddr_i(sp_top),
    .rdata_o(stack_top_value)
  );

  // pointer steps back one entry per pop
  assign sp_d = pop ? sp_top : (push_fire ? sp_q + SP_W'(1) : sp_q);

  // ****************************************************************
  // next values of state and core registers
  // ****************************************************************
  // a return spends a second cycle while the top is read
  assign state_d = do_ret ? rrre_pkg::ST_SECOND : rrre_pkg::ST_IDLE;

  // hardware set wins over a software clear
  assign global_irq_enable_d = (pop && ret_irq_q) ? 1'b1
      : (wr_irq ? WB_DAT_I[rrre_pkg::IRQ_EN_BIT] : global_irq_enable_q);
  // the reset opcode clear wins over a software write
  assign soft_reset_indicator_d = do_reset ? 1'b0
      : (wr_pwr ? WB_DAT_I[rrre_pkg::SRI_BIT] : soft_reset_indicator_q);
  // only the rotate and a core status write touch carry
  assign carry_d = do_rot ? FILE_RDATA_I[7]
      : (wr_stat ? WB_DAT_I[rrre_pkg::CARRY_BIT] : carry_q);
  assign w_d = (pop && ret_lit_q) ? lit_q
      : ((do_rot && !rot_to_file) ? rot_result
      : (wr_work ? WB_DAT_I[7:0] : w_q));

  // ****************************************************************
  // state and stack registers
  // ****************************************************************
  // sequencer, pointer and latched return kind
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q <= rrre_pkg::ST_IDLE;
      sp_q <= '0;
      ret_irq_q <= 1'b0;
      ret_lit_q <= 1'b0;
      lit_q <= 8'h00;
    end else begin
      state_q <= state_d;
      sp_q <= sp_d;
      ret_irq_q <= do_ret && is_ret_irq;
      ret_lit_q <= do_ret && is_ret_lit;
      lit_q <= do_ret ? INSTR_I[7:0] : lit_q;
    end
  end

  // ****************************************************************
  // core registers
  // ****************************************************************
  // flags, working register and power status
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      global_irq_enable_q <= rrre_pkg::RST_IRQ_EN;
      soft_reset_indicator_q <= rrre_pkg::RST_SRI;
      carry_q <= rrre_pkg::RST_CARRY;
      w_q <= rrre_pkg::RST_WORK;
    end else begin
      global_irq_enable_q <= global_irq_enable_d;
      soft_reset_indicator_q <= soft_reset_indicator_d;
      carry_q <= carry_d;
      w_q <= w_d;
    end
  end

  // program counter load and reset request pulses
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pc_q <= '0;
      pc_load_q <= 1'b0;
      reset_req_q <= 1'b0;
    end else begin
      pc_q <= pop ? stack_top_value : pc_q;
      pc_load_q <= pop;
      reset_req_q <= do_reset;
    end
  end

  // rotate write back to the file register
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      file_we_q <= 1'b0;
      file_wdata_q <= 8'h00;
      file_waddr_q <= '0;
    end else begin
      file_we_q <= do_rot && rot_to_file;
      file_wdata_q <= do_rot ? rot_result : file_wdata_q;
      file_waddr_q <= do_rot ? FILE_RADDR_O : file_waddr_q;
    end
  end

  assign PC_O = pc_q;
  assign PC_LOAD_O = pc_load_q;
  assign W_O = w_q;
  assign CARRY_O = carry_q;
  assign GLOBAL_IRQ_ENABLE_O = global_irq_enable_q;
  assign DEV_RESET_REQ_O = reset_req_q;
  assign FILE_WE_O = file_we_q;
  assign FILE_WDATA_O = file_wdata_q;
  assign FILE_WADDR_O = file_waddr_q;

  // ****************************************************************
  // wishbone slave
  // ****************************************************************
  // writes land on the edge where ack is seen, lane 0 only
  assign bus_req = WB_CYC_I && WB_STB_I;
  assign bus_wr = bus_req && WB_WE_I && ack_q && WB_SEL_I[0];
  assign wr_irq = bus_wr && WB_ADR_I == rrre_pkg::REG_IRQ_CTRL;
  assign wr_pwr = bus_wr && WB_ADR_I == rrre_pkg::REG_PWR_STAT;
  assign wr_stat = bus_wr && WB_ADR_I == rrre_pkg::REG_CORE_STAT;
  assign wr_work = bus_wr && WB_ADR_I == rrre_pkg::REG_WORK;

  // read mux, unmapped offsets read zero
  always_comb begin
    rd_data = 32'h00000000;
    case (WB_ADR_I)
      rrre_pkg::REG_IRQ_CTRL: rd_data = 32'(global_irq_enable_q)
          << rrre_pkg::IRQ_EN_BIT;
      rrre_pkg::REG_PWR_STAT: rd_data = 32'(soft_reset_indicator_q)
          << rrre_pkg::SRI_BIT;
      rrre_pkg::REG_CORE_STAT: rd_data = 32'(carry_q) << rrre_pkg::CARRY_BIT;
      rrre_pkg::REG_WORK: rd_data = 32'(w_q);
      rrre_pkg::REG_STACK_PTR: rd_data = 32'(sp_q);
      rrre_pkg::REG_PROG_CNT: rd_data = 32'(pc_q);
      default: rd_data = 32'h00000000;
    endcase
  end

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= bus_req && !ack_q;
      dat_q <= (bus_req && !ack_q) ? rd_data : dat_q;
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_N_I);

  AST_RESET_REQ: assert property (do_reset |=> DEV_RESET_REQ_O
      ##1 (!DEV_RESET_REQ_O || $past(do_reset)))
    else $error("software reset did not pulse the reset request");
  AST_RESET_FLAGS: assert property (do_reset |=> $stable(CARRY_O)
      && W_O == $past(W_O))
    else $error("software reset changed carry or W");
  AST_SRI_CLEAR: assert property (do_reset |=>
      !soft_reset_indicator_q)
    else $error("soft reset indicator not cleared");
  AST_RET_IRQ_PC: assert property (accept && is_ret_irq |=> ##1
      (PC_LOAD_O && PC_O == $past(stack_top_value)))
    else $error("interrupt return did not load the stack top");
  AST_RET_IRQ_EN: assert property (accept && is_ret_irq |=>
      !INSTR_READY_O ##1 (GLOBAL_IRQ_ENABLE_O && INSTR_READY_O))
    else $error("interrupt return did not set enable in two cycles");
  AST_RET_LIT_W: assert property (accept && is_ret_lit |-> ##2
      (W_O == $past(INSTR_I[7:0], 2) && PC_LOAD_O))
    else $error("literal return loaded the wrong W");
  AST_RETURN_TWO: assert property (accept && is_return |=>
      !INSTR_READY_O ##1 (INSTR_READY_O && PC_LOAD_O && $stable(CARRY_O)))
    else $error("plain return not two cycles or flags moved");
  AST_ROT_CARRY: assert property (do_rot |=>
      CARRY_O == $past(FILE_RDATA_I[7]))
    else $error("rotate carry is not old bit 7");
  AST_ROT_TO_W: assert property (do_rot && !rot_to_file |=>
      !FILE_WE_O && W_O == {$past(FILE_RDATA_I[6:0]), $past(CARRY_O)})
    else $error("rotate to W gave a wrong result");
  AST_ROT_TO_FILE: assert property (do_rot && rot_to_file |=>
      FILE_WE_O && FILE_WADDR_O == $past(INSTR_I[6:0])
      && W_O == $past(W_O))
    else $error("rotate to file did not write back");
  AST_ROT_ONE: assert property (do_rot |=> INSTR_READY_O)
    else $error("rotate took more than one cycle");
  AST_POP_SP: assert property (PC_LOAD_O |->
      (sp_q + SP_W'(1)) == $past(sp_q))
    else $error("pop did not step the pointer back by one");

  COV_RET_IRQ: cover property (accept && is_ret_irq ##2 GLOBAL_IRQ_ENABLE_O);
  COV_RET_LIT: cover property (accept && is_ret_lit ##2 PC_LOAD_O);
  COV_ROT_FILE: cover property (do_rot && rot_to_file ##1 FILE_WE_O);
  COV_RESET: cover property (do_reset ##1 DEV_RESET_REQ_O);
  COV_PUSH_POP: cover property (push_fire ##1 (accept && is_return));
endmodule : rrre_exec
`default_nettype wire

// ===== testbench.sv
// self-checking testbench of the return, reset and rotate execution block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // ****************************************************************
  // clock, reset and stimulus signals
  // ****************************************************************
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_w = 32'h0, dat_r;
  logic ack, ivalid = 1'b0, iready, push = 1'b0, push_rdy, fwe;
  logic [15:0] instr = 16'h0000;
  logic [6:0] fraddr, fwaddr;
  logic [7:0] frdata = 8'h00, fwdata, w;
  logic [14:0] push_val = 15'h0000, pc;
  logic pc_ld, carry, irq_en, devrst;
  int seed, errors = 0, samples_checked = 0;
  logic c_m = 1'b0;
  logic [7:0] w_m = 8'h00;
  logic [14:0] stk[$];

  // free-running 250 MHz clock
  always #2 mclk = ~mclk;

  rrre_exec #(.STACK_DEPTH(16)) dut (
    .MCLK_I(mclk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w),
    .WB_DAT_O(dat_r), .WB_ACK_O(ack), .INSTR_VALID_I(ivalid),
    .INSTR_I(instr), .INSTR_READY_O(iready), .FILE_RADDR_O(fraddr),
    .FILE_RDATA_I(frdata), .FILE_WADDR_O(fwaddr), .FILE_WDATA_O(fwdata),
    .FILE_WE_O(fwe), .PUSH_I(push), .PUSH_PC_I(push_val),
    .PUSH_READY_O(push_rdy), .PC_O(pc), .PC_LOAD_O(pc_ld), .W_O(w),
    .CARRY_O(carry), .GLOBAL_IRQ_ENABLE_O(irq_en), .DEV_RESET_REQ_O(devrst)
  );

  // ****************************************************************
  // comparison, verdict and bounded waits
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  // one clock edge of a bounded wait; a spent bound ends the run
  task automatic tick(inout int n);
    @(posedge mclk);
    n++;
    if (n > 20) begin
      errors++;
      end_sim();
    end
  endtask : tick

  // classic wishbone cycle, held until ack is sampled high
  task automatic wb(input logic wr, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    dat_w <= d;
    sel <= s;
    do tick(n); while (ack !== 1'b1);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    logic [31:0] q;
    wb(1'b1, a, d, s, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'hF, q);
    chk(nm, q, e);
  endtask : rd

  // offers one instruction; returns just after the edge that took it
  task automatic issue(input logic [15:0] op, input logic [7:0] fd);
    int n;
    n = 0;
    @(posedge mclk);
    ivalid <= 1'b1;
    instr <= op;
    frdata <= fd;
    do tick(n); while (iready !== 1'b1);
    ivalid <= 1'b0;
    #1;
  endtask : issue

  task automatic push_one(input logic [14:0] v);
    int n;
    n = 0;
    @(posedge mclk);
    push <= 1'b1;
    push_val <= v;
    do tick(n); while (push_rdy !== 1'b1);
    push <= 1'b0;
    stk.push_back(v);
  endtask : push_one

  // a return pops the last pushed address after two cycles
  task automatic ret_chk(input logic [15:0] op, input logic g);
    logic [14:0] top;
    top = stk.pop_back();
    issue(op, 8'h00);
    chk("ready_second", 32'(iready), 32'h0);
    chk("pc_load_early", 32'(pc_ld), 32'h0);
    chk("push_busy", 32'(push_rdy), 32'h0);
    @(posedge mclk);
    #1;
    chk("pc_load", 32'(pc_ld), 32'h1);
    chk("pc", 32'(pc), 32'(top));
    chk("w_ret", 32'(w), 32'(w_m));
    chk("irq_en", 32'(irq_en), 32'(g));
    chk("carry_ret", 32'(carry), 32'(c_m));
    rd(rrre_pkg::REG_STACK_PTR, 32'(stk.size()), "sp");
  endtask : ret_chk

  // rotate result: top bit is the new carry, low byte the value
  function automatic logic [8:0] rot(input logic [7:0] v, input logic c);
    return {v, c};
  endfunction : rot

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [7:0] fv;
    logic [6:0] f;
    logic d;
    logic [8:0] e;
    logic [7:0] corner[3];
    seed = 6;
    corner = '{8'hFF, 8'h80, 8'h00};
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rd(rrre_pkg::REG_IRQ_CTRL, 32'h0, "irq_en_rst");
    rd(rrre_pkg::REG_PWR_STAT, 32'h4, "sri_rst");
    rd(rrre_pkg::REG_CORE_STAT, 32'h0, "carry_rst");
    rd(8'h40, 32'h0, "unmapped");
    wr(rrre_pkg::REG_WORK, 32'h5A, 4'h0);
    rd(rrre_pkg::REG_WORK, 32'h0, "w_sel_off");
    $display("test registers done");
    for (int i = 0; i < 16; i++) begin
      fv = (i < 3) ? corner[i] : 8'($random(seed));
      f = 7'($random(seed));
      d = (i < 3) ? 1'(i) : 1'($random(seed));
      c_m = (i < 3) ? ~fv[7] : 1'($random(seed));
      wr(rrre_pkg::REG_CORE_STAT, 32'(c_m), 4'h1);
      e = rot(fv, c_m);
      issue({rrre_pkg::OP_ROT_HI, d, 1'($random(seed)), 1'b0, f}, fv);
      chk("file_raddr", 32'(fraddr), 32'(f));
      chk("carry_rot", 32'(carry), 32'(e[8]));
      chk("file_we", 32'(fwe), 32'(d));
      if (d) begin
        chk("file_wdata", 32'(fwdata), 32'(e[7:0]));
        chk("file_waddr", 32'(fwaddr), 32'(f));
      end else begin
        w_m = e[7:0];
      end
      chk("w_rot", 32'(w), 32'(w_m));
      c_m = e[8];
      @(posedge mclk);
      #1;
      chk("file_we_end", 32'(fwe), 32'h0);
    end
    $display("test rotate done");
    repeat (4) push_one(15'($random(seed)));
    rd(rrre_pkg::REG_STACK_PTR, 32'h4, "sp_push");
    ret_chk(16'h0012, 1'b0);
    ret_chk(16'h0013, 1'b0);
    w_m = 8'($random(seed));
    ret_chk({rrre_pkg::OP_RET_LIT_HI, w_m}, 1'b0);
    ret_chk(rrre_pkg::OP_RET_IRQ, 1'b1);
    $display("test returns done");
    issue(rrre_pkg::OP_RESET, 8'h00);
    chk("dev_reset", 32'(devrst), 32'h1);
    chk("carry_reset", 32'(carry), 32'(c_m));
    chk("w_reset", 32'(w), 32'(w_m));
    @(posedge mclk);
    #1;
    chk("dev_reset_end", 32'(devrst), 32'h0);
    rd(rrre_pkg::REG_PWR_STAT, 32'h0, "sri_cleared");
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rd(rrre_pkg::REG_PWR_STAT, 32'h4, "sri_again");
    $display("test soft reset done");
    end_sim();
  end
endmodule : testbench
`default_nettype wire
